// *** design/ssp_decoder_regs.svh ***
// System space offsets, field positions and fixed values for the decoder
`ifndef SSP_DECODER_REGS_SVH
`define SSP_DECODER_REGS_SVH

// Offsets within the top 16 MB window (address bits 23:0)
`define SSP_SYS_ARCH_HI 24'h00_0FFF
`define SSP_SYS_SPEC_LO 24'h00_1000
`define SSP_SYS_SPEC_HI 24'h00_1FFF
`define SSP_INTR_LO 24'h10_0000
`define SSP_INTR_HI 24'h17_FFFF
`define SSP_MASK_LO 24'h18_0000
`define SSP_MASK_HI 24'h18_1FFF
`define SSP_VEC_LO 24'h18_2000
`define SSP_VEC_HI 24'h18_2003
`define SSP_CFG_ARCH_LO 24'h20_0000
`define SSP_CFG_ARCH_HI 24'h20_0FFF
`define SSP_CFG_DEV_LO 24'h20_1000
`define SSP_CFG_DEV_HI 24'h20_1FFF
`define SSP_NVRAM_LO 24'h60_0000
`define SSP_NVRAM_HI 24'h7F_FFFF
`define SSP_FEAT_LO 24'hA0_0000
`define SSP_FEAT_HI 24'hBF_FFFF
`define SSP_BOOT_LO 24'hE0_0000

// Field positions of the address
`define SSP_SPACE_LSB 24
`define SSP_WIDE_LSB 32
`define SSP_RELOC_LSB 13

// Fixed values
`define SSP_HALF_STEP 24'h00_1000
`define SSP_TOP_BYTE 8'hFF
`define SSP_ZERO_DATA 32'h0000_0000

`endif

// *** design/ssp_decoder_pkg.sv ***
// Types shared by the system space decoder
package ssp_decoder_pkg;

  // One-hot region selects; none means outside the system space
  typedef enum logic [10:0] {
    REG_NONE = 11'h000,
    REG_SYS_ARCH = 11'h001,
    REG_SYS_SPEC = 11'h002,
    REG_INTR = 11'h004,
    REG_ROUTE_MASK = 11'h008,
    REG_EXT_VECTOR = 11'h010,
    REG_CFG_ARCH = 11'h020,
    REG_CFG_DEV = 11'h040,
    REG_NVRAM = 11'h080,
    REG_PRODUCT_ROM = 11'h100,
    REG_BOOT_ROM = 11'h200,
    REG_RESERVED = 11'h400
  } region_e;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } state_e;

endpackage

// *** design/system_space_address_decoder.sv ***
// System space address decoder with I/O completion tracking and barrier drain
`timescale 1ns/10ps
`default_nettype none
`include "ssp_decoder_regs.svh"

module system_space_address_decoder
  import ssp_decoder_pkg::*;
#(
  parameter int ADDR_W = 64,
  parameter int DATA_W = 32,
  parameter int MAX_PEND = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Processor request
  input wire logic i_req_valid,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic [DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  // Processor answer
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  output logic o_rsp_error,
  // Region targets and main memory
  output logic [10:0] o_region_sel,
  output logic o_tgt_valid,
  output logic o_mem_valid,
  output logic [ADDR_W-1:0] o_tgt_addr,
  output logic o_tgt_write,
  output logic [DATA_W-1:0] o_tgt_wdata,
  input wire logic i_tgt_ack,
  input wire logic [DATA_W-1:0] i_tgt_rdata,
  input wire logic i_tgt_error,
  // Ordering barrier
  input wire logic i_barrier_req,
  output logic o_barrier_done,
  // Completion status
  output logic o_io_idle,
  output logic o_io_done,
  output logic o_io_done_error,
  output logic [$clog2(MAX_PEND+1)-1:0] o_pending_count,
  // Route mask relocation
  input wire logic i_mask_reloc_en,
  input wire logic [31:`SSP_RELOC_LSB] i_mask_reloc_base,
  output logic o_reloc_conflict
);

  localparam int PEND_W = $clog2(MAX_PEND + 1);
  localparam int RB_W = 32 - `SSP_RELOC_LSB;

  // Upper bits all ones: system window or top four gigabytes
  function automatic logic top_ones(input logic [ADDR_W-1:0] a, input int lsb);
    logic [ADDR_W:0] ext;
    logic ok;
    ext = {1'b1, a};
    ok = 1'b1;
    for (int i = 0; i <= ADDR_W; i++) begin
      if (i >= lsb && ext[i] == 1'b0) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Region of an offset inside the 16 MB window
  function automatic region_e decode_offset(input logic [23:0] off, input logic mask_home);
    region_e r;
    r = REG_RESERVED;
    if (off <= `SSP_SYS_ARCH_HI) begin
      r = REG_SYS_ARCH;
    end else if (off >= `SSP_SYS_SPEC_LO && off <= `SSP_SYS_SPEC_HI) begin
      r = REG_SYS_SPEC;
    end else if (off >= `SSP_INTR_LO && off <= `SSP_INTR_HI) begin
      r = REG_INTR;
    end else if (off >= `SSP_MASK_LO && off <= `SSP_MASK_HI) begin
      if (mask_home) begin
        r = REG_ROUTE_MASK;
      end
    end else if (off >= `SSP_VEC_LO && off <= `SSP_VEC_HI) begin
      r = REG_EXT_VECTOR;
    end else if (off >= `SSP_CFG_ARCH_LO && off <= `SSP_CFG_ARCH_HI) begin
      r = REG_CFG_ARCH;
    end else if (off >= `SSP_CFG_DEV_LO && off <= `SSP_CFG_DEV_HI) begin
      r = REG_CFG_DEV;
    end else if (off >= `SSP_NVRAM_LO && off <= `SSP_NVRAM_HI) begin
      r = REG_NVRAM;
    end else if (off >= `SSP_FEAT_LO && off <= `SSP_FEAT_HI) begin
      r = REG_PRODUCT_ROM;
    end else if (off >= `SSP_BOOT_LO) begin
      r = REG_BOOT_ROM;
    end
    return r;
  endfunction

  state_e state;
  state_e next_state;
  logic reloc_ok;
  logic next_reloc_ok;
  logic [PEND_W-1:0] pending;
  logic [PEND_W-1:0] next_pending;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic next_rsp_error;
  logic [10:0] next_region_sel;
  logic next_tgt_valid;
  logic next_mem_valid;
  logic [ADDR_W-1:0] next_tgt_addr;
  logic next_tgt_write;
  logic [DATA_W-1:0] next_tgt_wdata;
  logic next_barrier_done;
  logic next_io_done;
  logic next_io_done_error;
  logic next_reloc_conflict;
  logic conflict_now;
  logic [23:0] reloc_off;
  logic accept;
  logic ack_write;
  logic pend_inc;
  logic region_in_space;
  logic mask_moved_hit;
  region_e region;

  // Relocation target checked against every fixed region except the mask's own home, both 4 KB halves
  always_comb begin
    reloc_off = {i_mask_reloc_base[`SSP_SPACE_LSB-1:`SSP_RELOC_LSB],
                 {`SSP_RELOC_LSB{1'b0}}};
    conflict_now = 1'b0;
    if (i_mask_reloc_base[31:`SSP_SPACE_LSB] == `SSP_TOP_BYTE) begin
      if (decode_offset(reloc_off, 1'b0) != REG_RESERVED ||
          decode_offset(reloc_off + `SSP_HALF_STEP, 1'b0) != REG_RESERVED) begin
        conflict_now = i_mask_reloc_en;
      end
    end
  end

  // Region of the incoming address; moved masks win only when accepted
  always_comb begin
    region_in_space = top_ones(i_req_addr, `SSP_SPACE_LSB);
    mask_moved_hit = reloc_ok && top_ones(i_req_addr, `SSP_WIDE_LSB) &&
                     i_req_addr[31:`SSP_RELOC_LSB] == i_mask_reloc_base;
    if (mask_moved_hit) begin
      region = REG_ROUTE_MASK;
    end else if (region_in_space) begin
      region = decode_offset(i_req_addr[`SSP_SPACE_LSB-1:0], !reloc_ok);
    end else begin
      region = REG_NONE;
    end
  end

  // Sequencer, posted writes, completion count and barrier
  always_comb begin
    next_state = state;
    next_pending = pending;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = o_rsp_rdata;
    next_rsp_error = o_rsp_error;
    next_region_sel = o_region_sel;
    next_tgt_valid = 1'b0;
    next_mem_valid = 1'b0;
    next_tgt_addr = o_tgt_addr;
    next_tgt_write = o_tgt_write;
    next_tgt_wdata = o_tgt_wdata;
    next_barrier_done = 1'b0;
    next_io_done = 1'b0;
    next_io_done_error = o_io_done_error;
    next_reloc_conflict = conflict_now;
    next_reloc_ok = i_mask_reloc_en && !conflict_now;
    pend_inc = 1'b0;
    accept = i_req_valid && o_req_ready && state == ST_IDLE;
    // Targets answer in issue order, so early acks retire posted writes
    ack_write = i_tgt_ack && pending != '0;
    if (ack_write) begin
      // Ack means every side effect, status and interrupt, has happened
      next_io_done = 1'b1;
      next_io_done_error = i_tgt_error;
    end
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_region_sel = region;
          next_tgt_addr = i_req_addr;
          next_tgt_write = i_req_write;
          next_tgt_wdata = i_req_wdata;
          if (region == REG_RESERVED) begin
            // No target behind it: write dropped, read gives zeros
            next_rsp_valid = 1'b1;
            next_rsp_rdata = `SSP_ZERO_DATA;
            next_rsp_error = 1'b0;
          end else begin
            if (region == REG_NONE) begin
              next_mem_valid = 1'b1;
            end else begin
              next_tgt_valid = 1'b1;
            end
            if (i_req_write) begin
              // Posted: answer now, finish counted when target acks
              next_rsp_valid = 1'b1;
              next_rsp_error = 1'b0;
              pend_inc = 1'b1;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end else if (i_barrier_req && pending == '0 && !o_barrier_done) begin
          next_barrier_done = 1'b1;
        end
      end
      ST_WAIT: begin
        if (i_tgt_ack && pending == '0) begin
          // Read returns once all earlier writes have retired
          next_rsp_valid = 1'b1;
          next_rsp_rdata = i_tgt_rdata;
          next_rsp_error = i_tgt_error;
          next_io_done = 1'b1;
          next_io_done_error = i_tgt_error;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_pending = pending + {{(PEND_W-1){1'b0}}, pend_inc}
                   - {{(PEND_W-1){1'b0}}, ack_write};
    // Barrier holds new requests from the cycle after i_barrier_req rises until the cycle after it falls
    next_req_ready = next_state == ST_IDLE && !i_barrier_req &&
                     next_pending != PEND_W'(MAX_PEND);
  end

  // Register stage; every output leaves from here
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      pending <= '0;
      reloc_ok <= 1'b0;
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
      o_rsp_error <= 1'b0;
      o_region_sel <= REG_NONE;
      o_tgt_valid <= 1'b0;
      o_mem_valid <= 1'b0;
      o_tgt_addr <= '0;
      o_tgt_write <= 1'b0;
      o_tgt_wdata <= '0;
      o_barrier_done <= 1'b0;
      o_io_idle <= 1'b1;
      o_io_done <= 1'b0;
      o_io_done_error <= 1'b0;
      o_pending_count <= '0;
      o_reloc_conflict <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
      reloc_ok <= next_reloc_ok;
      o_req_ready <= next_req_ready;
      o_rsp_valid <= next_rsp_valid;
      o_rsp_rdata <= next_rsp_rdata;
      o_rsp_error <= next_rsp_error;
      o_region_sel <= next_region_sel;
      o_tgt_valid <= next_tgt_valid;
      o_mem_valid <= next_mem_valid;
      o_tgt_addr <= next_tgt_addr;
      o_tgt_write <= next_tgt_write;
      o_tgt_wdata <= next_tgt_wdata;
      o_barrier_done <= next_barrier_done;
      o_io_idle <= next_pending == '0 && next_state == ST_IDLE;
      o_io_done <= next_io_done;
      o_io_done_error <= next_io_done_error;
      o_pending_count <= next_pending;
      o_reloc_conflict <= next_reloc_conflict;
    end
  end

endmodule
`default_nettype wire

// *** verification/ssp_decoder_checker_sva.sv ***
// Port checker for the system space decoder
`timescale 1ns/10ps
`default_nettype none
module ssp_decoder_checker #(parameter int MAX_PEND = 8) (
  // Clock, reset and inputs
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire logic [63:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic i_tgt_ack,
  input wire logic i_barrier_req,
  // Design outputs
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic [31:0] o_rsp_rdata,
  input wire logic [10:0] o_region_sel,
  input wire logic o_tgt_valid,
  input wire logic o_mem_valid,
  input wire logic o_tgt_write,
  input wire logic o_barrier_done,
  input wire logic o_io_done,
  input wire logic [$clog2(MAX_PEND+1)-1:0] o_pending_count
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Taken requests, by kind
  sequence s_take; i_req_valid && o_req_ready; endsequence
  sequence s_take_rd; s_take and !i_req_write; endsequence
  AST_TGT_ONEHOT: assert property (o_tgt_valid |-> $onehot(o_region_sel) && !o_region_sel[10])
    else $error("target pulse without one region");
  AST_MEM_NOSEL: assert property (o_mem_valid |-> o_region_sel == 11'h000 && !o_tgt_valid)
    else $error("memory access with a region");
  AST_TOP_SPACE: assert property (s_take and &i_req_addr[63:24] |=> o_region_sel != 11'h000)
    else $error("system space left unselected");
  AST_LOW_SPACE: assert property (s_take and !(&i_req_addr[63:32]) |=> o_region_sel == 11'h000)
    else $error("region outside system space");
  AST_WR_ANSWER: assert property (s_take and i_req_write |=> o_rsp_valid)
    else $error("write not answered");
  AST_RSV_ZERO: assert property (s_take_rd ##1 o_region_sel[10] |-> o_rsp_valid && o_rsp_rdata == 32'h0000_0000)
    else $error("reserved read not zero");
  AST_RD_NOT_EARLY: assert property (o_tgt_valid && !o_tgt_write |-> !o_rsp_valid)
    else $error("read answered at issue");
  AST_ACK_DONE: assert property (i_tgt_ack |=> o_io_done)
    else $error("ack without completion");
  AST_BAR_DRAINED: assert property (o_barrier_done |-> o_pending_count == '0)
    else $error("barrier done with writes pending");
  AST_BAR_HOLD: assert property (i_barrier_req ##1 i_barrier_req |=> !o_req_ready)
    else $error("requests open during barrier");
endmodule
`default_nettype wire

// *** verification/ssp_target_model.sv ***
// Region target model: acks issued accesses in order
`timescale 1ns/10ps
`default_nettype none
module ssp_target_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Issue side
  input wire logic i_issue,
  input wire logic i_slow,
  input wire logic [63:0] i_addr,
  // Answer side
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_error
);
  logic [63:0] q[$];
  int wait_n;
  // Ack oldest access after one or six cycles; data toggles when idle
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q.delete();
      wait_n = 0;
      o_ack <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_error <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      o_error <= ~o_error;
      if (i_issue) q.push_back(i_addr);
      if (q.size() > 0 && wait_n >= (i_slow ? 6 : 1)) begin
        o_ack <= 1'b1;
        o_rdata <= q[0][31:0] ^ 32'h5A5A_0000;
        o_error <= (q[0][3:2] == 2'b11);
        q.pop_front();
        wait_n = 0;
      end else if (q.size() > 0) wait_n++;
    end
  end
endmodule
`default_nettype wire

// *** verification/system_space_address_decoder_bench.sv ***
// Self-checking bench for the system space decoder
`timescale 1ns/10ps
`default_nettype none
module system_space_address_decoder_bench;
  localparam logic [39:0] HI = 40'hFF_FFFF_FFFF;
  localparam logic [23:0] OFS [16] = '{24'h00_0000, 24'h00_1FFF, 24'h00_2000, 24'h17_FFFF,
    24'h18_0000, 24'h18_2003, 24'h18_2004, 24'h20_0FFF, 24'h20_1000, 24'h20_2000,
    24'h7F_FFFF, 24'h80_0000, 24'hA0_0000, 24'hC0_0000, 24'hFF_FFFF, 24'h0F_FFFF};
  localparam int SB [16] = '{0, 1, 10, 2, 3, 4, 10, 5, 6, 10, 7, 10, 8, 10, 9, 10};
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr = 1'b0, slow = 1'b0, bar = 1'b0, ren = 1'b0;
  logic [18:0] rbase = 19'h0_0000;
  logic [63:0] addr = 64'h0, taddr;
  logic [31:0] wdata = 32'h0, rdata, trd, r;
  logic [10:0] sel;
  logic [1:0] pend;
  logic [44:0] e;
  logic rv, rerr, rdy, tv, mv, tw, ack, terr, bdone, conf;
  logic [44:0] exp_q[$];
  int n_mismatch = 0, comparisons = 0;
  always #5 clk = ~clk;
  system_space_address_decoder #(.MAX_PEND(2)) u_system_space_address_decoder (
    .i_clock(clk), .i_reset_n(rst_n), .i_req_valid(vld), .i_req_addr(addr), .i_req_write(wr),
    .i_req_wdata(wdata), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rdata),
    .o_rsp_error(rerr), .o_region_sel(sel), .o_tgt_valid(tv), .o_mem_valid(mv),
    .o_tgt_addr(taddr), .o_tgt_write(tw), .o_tgt_wdata(), .i_tgt_ack(ack), .i_tgt_rdata(trd),
    .i_tgt_error(terr), .i_barrier_req(bar), .o_barrier_done(bdone), .o_io_idle(),
    .o_io_done(), .o_io_done_error(), .o_pending_count(pend), .i_mask_reloc_en(ren),
    .i_mask_reloc_base(rbase), .o_reloc_conflict(conf));
  ssp_target_model u_ssp_target_model (.i_clock(clk), .i_reset_n(rst_n), .i_issue(tv | mv),
    .i_slow(slow), .i_addr(taddr), .o_ack(ack), .o_rdata(trd), .o_error(terr));
  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hold one access until taken, then note the expected answer
  task automatic access(input logic [63:0] a, input logic w, input logic [10:0] s);
    vld <= 1'b1;
    addr <= a;
    wr <= w;
    wdata <= $urandom;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    exp_q.push_back({!w, (w || s[10]) ? 32'h0 : a[31:0] ^ 32'h5A5A_0000,
      !w && !s[10] && a[3:2] == 2'b11, s});
  endtask
  // Answers in take order; data only for reads
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      e = exp_q.pop_front();
      check("region", e[10:0], sel);
      check("error", e[11], rerr);
      if (e[44]) check("rdata", e[43:12], rdata);
    end
  end
  initial begin
    r = $urandom(32'h0000_C2B3);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int w = 0; w < 2; w++)
      for (int i = 0; i < 16; i++) access({HI, OFS[i]}, w[0], 11'h001 << SB[i]);
    access(64'h0000_0000_FF00_0000, 1'b0, 11'h000);
    access(64'h0000_0000_0012_345C, 1'b0, 11'h000);
    slow <= 1'b1;
    repeat (8) begin
      r = $urandom;
      access({HI, 3'b011, r[20:0]}, r[31], 11'h080);
    end
    vld <= 1'b0;
    bar <= 1'b1;
    for (int t = 0; t < 100 && bdone !== 1'b1; t++) @(negedge clk);
    check("pending", 32'h0, pend);
    @(posedge clk);
    bar <= 1'b0;
    ren <= 1'b1;
    rbase <= 19'h7_F000;
    repeat (3) @(posedge clk);
    check("conflict", 32'h0, conf);
    access(64'hFFFF_FFFF_FE00_0004, 1'b0, 11'h008);
    access({HI, 24'h18_0000}, 1'b0, 11'h400);
    vld <= 1'b0;
    rbase <= 19'h7_F800;
    repeat (3) @(posedge clk);
    check("conflict", 32'h1, conf);
    access({HI, 24'h18_0004}, 1'b0, 11'h008);
    vld <= 1'b0;
    repeat (20) @(posedge clk);
    check("left", 32'h0, exp_q.size());
    close_out();
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule
bind system_space_address_decoder ssp_decoder_checker #(.MAX_PEND(MAX_PEND)) u_chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid), .i_req_addr(i_req_addr),
  .i_req_write(i_req_write), .i_tgt_ack(i_tgt_ack), .i_barrier_req(i_barrier_req),
  .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
  .o_region_sel(o_region_sel), .o_tgt_valid(o_tgt_valid), .o_mem_valid(o_mem_valid),
  .o_tgt_write(o_tgt_write), .o_barrier_done(o_barrier_done), .o_io_done(o_io_done),
  .o_pending_count(o_pending_count));
`default_nettype wire
